// file: sisp_pkg.sv
package sisp_pkg;
    // instruction opcodes (first byte), sub-opcodes (second byte) and other byte values
    localparam logic [7:0] OP_ENABLE = 8'hAC;
    localparam logic [7:0] SUB_ENABLE = 8'h53;
    localparam logic [7:0] SUB_ERASE = 8'h80;
    localparam logic [7:0] SUB_LOCK_W = 8'hE0;
    localparam logic [7:0] SUB_FUSE_LO_W = 8'hA0;
    localparam logic [7:0] SUB_FUSE_HI_W = 8'hA8;
    localparam logic [7:0] SUB_FUSE_EX_W = 8'hA4;
    localparam logic [7:0] OP_POLL = 8'hF0;
    localparam logic [7:0] OP_EXT_ADDR = 8'h4D;
    localparam logic [7:0] OP_LOAD_HI = 8'h48;
    localparam logic [7:0] OP_LOAD_LO = 8'h40;
    localparam logic [7:0] OP_EE_LOAD = 8'hC1;
    localparam logic [7:0] OP_READ_HI = 8'h28;
    localparam logic [7:0] OP_READ_LO = 8'h20;
    localparam logic [7:0] OP_EE_READ = 8'hA0;
    localparam logic [7:0] OP_READ_LOCK_HI = 8'h58;
    localparam logic [7:0] OP_READ_FUSE = 8'h50;
    localparam logic [7:0] SEL_HIGH = 8'h08;
    localparam logic [7:0] OP_READ_SIG = 8'h30;
    localparam logic [7:0] OP_READ_CAL = 8'h38;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h4C;
    localparam logic [7:0] OP_EE_WRITE = 8'hC0;
    localparam logic [7:0] OP_EE_PAGE_WRITE = 8'hC2;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // memory geometry
    localparam int PAGE_BITS = 6;
    localparam int PAGE_SEL_BITS = 7;
    localparam int WORD_ADDR_BITS = PAGE_BITS + PAGE_SEL_BITS;
    localparam int EE_ADDR_BITS = 10;
    localparam int EE_PAGE_BITS = 2;
    localparam int FRAME_BITS = 32;
    // timing, then identity and fuse reset values
    localparam int CLK_HZ = 10_000_000;
    localparam real PAGE_WRITE_WAIT_MS = 4.5;
    localparam real EEPROM_WRITE_WAIT_MS = 3.6;
    localparam real ERASE_WAIT_MS = 9.0;
    localparam real POWERUP_WAIT_MS = 20.0;
    localparam int PAGE_WRITE_WAIT_CYC = int'($ceil(PAGE_WRITE_WAIT_MS * CLK_HZ / 1000.0));
    localparam int EEPROM_WRITE_WAIT_CYC = int'($ceil(EEPROM_WRITE_WAIT_MS * CLK_HZ / 1000.0));
    localparam int ERASE_WAIT_CYC = int'($ceil(ERASE_WAIT_MS * CLK_HZ / 1000.0));
    localparam int POWERUP_WAIT_CYC = int'($ceil(POWERUP_WAIT_MS * CLK_HZ / 1000.0));
    localparam int SCK_HALF_CYC = 4;
    localparam int RESET_PULSE_CYC = 2;
    localparam logic [7:0] SIG_BYTE0 = 8'h11;
    localparam logic [7:0] SIG_BYTE1 = 8'h22;
    localparam logic [7:0] SIG_BYTE2 = 8'h33;
    localparam logic [7:0] CAL_BYTE = 8'h80;
    localparam logic [7:0] FUSE_RESET = 8'hFF;
endpackage : sisp_pkg

// file: sisp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sisp_if;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic rst_pin_n;
    modport device (input sck, input mosi, input rst_pin_n, output miso, output miso_oe);
    modport prog (output sck, output mosi, output rst_pin_n, input miso, input miso_oe);
endinterface : sisp_if
`default_nettype wire

// file: sisp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sisp_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule : sisp_sync
`default_nettype wire

// file: sisp_device.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module sisp_device (
    input wire logic CLK,
    input wire logic RESET_N,
    sisp_if.device LINK,
    output logic PROG_MODE,
    output logic BUSY
);
    localparam int WA = sisp_pkg::WORD_ADDR_BITS;
    localparam int EA = sisp_pkg::EE_ADDR_BITS;
    localparam int PB = sisp_pkg::PAGE_BITS;
    logic [15:0] flash_mem [0:(1<<WA)-1];
    logic [7:0] ee_mem [0:(1<<EA)-1];
    logic [15:0] page_buf [0:(1<<PB)-1];
    logic [7:0] ee_buf [0:(1<<sisp_pkg::EE_PAGE_BITS)-1];
    logic [(1<<sisp_pkg::EE_PAGE_BITS)-1:0] ee_loaded_r;
    logic sck_s, mosi_s, rst_s;
    sisp_sync u_sck (.clk(CLK), .reset_n(RESET_N), .d(LINK.sck), .q(sck_s));
    sisp_sync u_mosi (.clk(CLK), .reset_n(RESET_N), .d(LINK.mosi), .q(mosi_s));
    sisp_sync u_rst (.clk(CLK), .reset_n(RESET_N), .d(LINK.rst_pin_n), .q(rst_s));

    //////////////////////////////////////////////////////////////////////////
    logic sck_d_r, sck_d_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [7:0] out_r, out_nxt;
    logic miso_r, miso_nxt;
    logic en_r, en_nxt;
    logic frame_done;
    logic [31:0] frame;
    logic rise, fall;
    assign rise = sck_s & ~sck_d_r;
    assign fall = ~sck_s & sck_d_r;
    // session only exists while the reset pin is low
    assign LINK.miso_oe = ~rst_s;
    assign LINK.miso = miso_r;

    always_comb begin
        sck_d_nxt = sck_s;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        miso_nxt = miso_r;
        frame_done = 1'b0;
        frame = {sh_r[30:0], mosi_s};
        if (rst_s) begin
            cnt_nxt = 5'h00;
            sh_nxt = 32'h0;
            miso_nxt = 1'b0;
        end else begin
            if (rise) begin
                sh_nxt = frame;
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == 5'h1F) begin
                    frame_done = 1'b1;
                end
                // second byte echoes back during the third byte
                if (cnt_r == 5'h0F) begin
                    out_nxt = frame[7:0];
                end
                // after 24 bits the low three bytes hold opcode and both address bytes
                if (cnt_r == 5'h17) begin
                    out_nxt = read_byte(frame[23:0]);
                end
            end
            if (fall) begin
                miso_nxt = out_r[7];
                out_nxt = {out_r[6:0], 1'b0};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    logic [7:0] ext_r;
    logic [7:0] lock_r, fuse_lo_r, fuse_hi_r, fuse_ex_r;
    logic [23:0] busy_cnt_r;
    assign BUSY = (busy_cnt_r != 24'h0);
    assign PROG_MODE = en_r;

    function automatic logic [7:0] read_byte(input logic [23:0] f);
        logic [WA-1:0] wa;
        wa = f[WA-1:0];
        case (f[23:16])
            sisp_pkg::OP_POLL: read_byte = {7'h00, BUSY};
            sisp_pkg::OP_READ_LO: read_byte = flash_mem[wa][7:0];
            sisp_pkg::OP_READ_HI: read_byte = flash_mem[wa][15:8];
            sisp_pkg::OP_EE_READ: read_byte = ee_mem[f[EA-1:0]];
            sisp_pkg::OP_READ_SIG: read_byte = (f[1:0] == 2'h0) ? sisp_pkg::SIG_BYTE0 :
                                              (f[1:0] == 2'h1) ? sisp_pkg::SIG_BYTE1 : sisp_pkg::SIG_BYTE2;
            sisp_pkg::OP_READ_CAL: read_byte = sisp_pkg::CAL_BYTE;
            sisp_pkg::OP_READ_LOCK_HI: read_byte = (f[15:8] == sisp_pkg::SEL_HIGH) ? fuse_hi_r : lock_r;
            sisp_pkg::OP_READ_FUSE: read_byte = (f[15:8] == sisp_pkg::SEL_HIGH) ? fuse_ex_r : fuse_lo_r;
            default: read_byte = 8'h00;
        endcase
    endfunction : read_byte

    // programming mode and register state
    logic [23:0] busy_cnt_nxt;
    logic [7:0] ext_nxt, lock_nxt, fuse_lo_nxt, fuse_hi_nxt, fuse_ex_nxt;
    logic [(1<<sisp_pkg::EE_PAGE_BITS)-1:0] ee_loaded_nxt;
    logic [7:0] op, b2, b3, b4;
    assign op = frame[31:24];
    assign b2 = frame[23:16];
    assign b3 = frame[15:8];
    assign b4 = frame[7:0];
    logic allow;
    assign allow = frame_done & en_r & ~BUSY;

    always_comb begin
        en_nxt = en_r;
        busy_cnt_nxt = (busy_cnt_r != 24'h0) ? busy_cnt_r - 24'h1 : 24'h0;
        ext_nxt = ext_r;
        lock_nxt = lock_r;
        fuse_lo_nxt = fuse_lo_r;
        fuse_hi_nxt = fuse_hi_r;
        fuse_ex_nxt = fuse_ex_r;
        ee_loaded_nxt = ee_loaded_r;
        if (rst_s) begin
            en_nxt = 1'b0;
        end else if (frame_done && op == sisp_pkg::OP_ENABLE && b2 == sisp_pkg::SUB_ENABLE) begin
            en_nxt = 1'b1;
        end else if (allow) begin
            case (op)
                sisp_pkg::OP_ENABLE: begin
                    case (b2)
                        sisp_pkg::SUB_ERASE: begin
                            busy_cnt_nxt = 24'(sisp_pkg::ERASE_WAIT_CYC);
                            lock_nxt = sisp_pkg::FUSE_RESET;
                        end
                        sisp_pkg::SUB_LOCK_W: lock_nxt = lock_r & b4;
                        sisp_pkg::SUB_FUSE_LO_W: fuse_lo_nxt = b4;
                        sisp_pkg::SUB_FUSE_HI_W: fuse_hi_nxt = b4;
                        sisp_pkg::SUB_FUSE_EX_W: fuse_ex_nxt = b4;
                        default: ;
                    endcase
                end
                sisp_pkg::OP_EXT_ADDR: ext_nxt = b3;
                sisp_pkg::OP_PAGE_WRITE: busy_cnt_nxt = 24'(sisp_pkg::PAGE_WRITE_WAIT_CYC);
                sisp_pkg::OP_EE_WRITE: busy_cnt_nxt = 24'(sisp_pkg::EEPROM_WRITE_WAIT_CYC);
                sisp_pkg::OP_EE_LOAD: ee_loaded_nxt = ee_loaded_r | (4'h1 << b3[1:0]);
                sisp_pkg::OP_EE_PAGE_WRITE: begin
                    busy_cnt_nxt = 24'(sisp_pkg::EEPROM_WRITE_WAIT_CYC);
                    ee_loaded_nxt = 4'h0;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sck_d_r <= 1'b0;
            sh_r <= 32'h0;
            cnt_r <= 5'h00;
            out_r <= 8'h00;
            miso_r <= 1'b0;
            en_r <= 1'b0;
            busy_cnt_r <= 24'h0;
            ext_r <= 8'h00;
            lock_r <= sisp_pkg::FUSE_RESET;
            fuse_lo_r <= sisp_pkg::FUSE_RESET;
            fuse_hi_r <= sisp_pkg::FUSE_RESET;
            fuse_ex_r <= sisp_pkg::FUSE_RESET;
            ee_loaded_r <= 4'h0;
        end else begin
            sck_d_r <= sck_d_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
            miso_r <= miso_nxt;
            en_r <= en_nxt;
            busy_cnt_r <= busy_cnt_nxt;
            ext_r <= ext_nxt;
            lock_r <= lock_nxt;
            fuse_lo_r <= fuse_lo_nxt;
            fuse_hi_r <= fuse_hi_nxt;
            fuse_ex_r <= fuse_ex_nxt;
            ee_loaded_r <= ee_loaded_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // memory arrays have no reset: contents are nonvolatile in intent
    always_ff @(posedge CLK) begin
        if (allow) begin
            case (op)
                sisp_pkg::OP_ENABLE: begin
                    if (b2 == sisp_pkg::SUB_ERASE) begin
                        for (int i = 0; i < (1<<WA); i++) flash_mem[i] <= 16'hFFFF;
                        for (int i = 0; i < (1<<EA); i++) ee_mem[i] <= sisp_pkg::ERASED_BYTE;
                    end
                end
                sisp_pkg::OP_LOAD_LO: page_buf[b3[PB-1:0]] <= {8'hFF, b4};
                sisp_pkg::OP_LOAD_HI: page_buf[b3[PB-1:0]][15:8] <= b4;
                sisp_pkg::OP_PAGE_WRITE: begin
                    for (int i = 0; i < (1<<PB); i++)
                        flash_mem[{b2[WA-9:0], b3[7:PB], PB'(i)}] <= page_buf[i];
                end
                // self-timed write overwrites the location: implicit erase
                sisp_pkg::OP_EE_WRITE: ee_mem[{b2[1:0], b3}] <= b4;
                sisp_pkg::OP_EE_LOAD: ee_buf[b3[1:0]] <= b4;
                sisp_pkg::OP_EE_PAGE_WRITE: begin
                    for (int i = 0; i < 4; i++)
                        if (ee_loaded_r[i]) ee_mem[{b2[1:0], b3[7:2], 2'(i)}] <= ee_buf[i];
                end
                default: ;
            endcase
        end
    end
endmodule : sisp_device
`default_nettype wire

// file: sisp_prog.sv
`timescale 1ns/1ps
`default_nettype none
module sisp_prog #(
    parameter int POWERUP_CYC = sisp_pkg::POWERUP_WAIT_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    sisp_if.prog LINK,
    input wire logic START,
    input wire logic [31:0] CMD,
    input wire logic SESSION,
    output logic READY,
    output logic DONE,
    output logic [7:0] ECHO,
    output logic [7:0] RDATA
);
    typedef enum logic [2:0] {
        SISP_PWR = 3'h0, SISP_IDLE = 3'h1, SISP_LO = 3'h2, SISP_HI = 3'h3, SISP_OFF = 3'h4
    } sisp_st_t;
    sisp_st_t st_r, st_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [5:0] bit_r, bit_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [31:0] rx_r, rx_nxt;
    logic sck_r, sck_nxt, rst_r, rst_nxt, done_nxt;
    logic [7:0] echo_nxt, rdata_nxt;
    logic miso_s;
    sisp_sync u_miso (.clk(CLK), .reset_n(RESET_N), .d(LINK.miso), .q(miso_s));
    assign LINK.sck = sck_r;
    assign LINK.mosi = sh_r[31];
    assign LINK.rst_pin_n = rst_r;
    assign READY = (st_r == SISP_IDLE);

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        tmr_nxt = (tmr_r != 32'h0) ? tmr_r - 32'h1 : 32'h0;
        rx_nxt = rx_r;
        sck_nxt = sck_r;
        rst_nxt = rst_r;
        done_nxt = 1'b0;
        echo_nxt = ECHO;
        rdata_nxt = RDATA;
        case (st_r)
            // reset and clock held low through the power-up wait
            SISP_PWR: if (tmr_r == 32'h0) st_nxt = SISP_IDLE;
            SISP_IDLE: begin
                rst_nxt = ~SESSION;
                if (!SESSION) begin
                    st_nxt = SISP_OFF;
                    tmr_nxt = 32'(sisp_pkg::RESET_PULSE_CYC);
                end else if (START) begin
                    sh_nxt = CMD;
                    bit_nxt = 6'h00;
                    tmr_nxt = 32'(sisp_pkg::SCK_HALF_CYC);
                    st_nxt = SISP_LO;
                end
            end
            SISP_LO: if (tmr_r == 32'h0) begin
                sck_nxt = 1'b1;
                tmr_nxt = 32'(sisp_pkg::SCK_HALF_CYC);
                st_nxt = SISP_HI;
            end
            SISP_HI: if (tmr_r == 32'h0) begin
                sck_nxt = 1'b0;
                // sampled late in the high phase: miso has crossed both sync stages by then
                rx_nxt = {rx_r[30:0], miso_s};
                sh_nxt = {sh_r[30:0], 1'b0};
                bit_nxt = bit_r + 6'h01;
                tmr_nxt = 32'(sisp_pkg::SCK_HALF_CYC);
                if (bit_r == 6'h1F) begin
                    st_nxt = SISP_IDLE;
                    done_nxt = 1'b1;
                    echo_nxt = rx_nxt[15:8];
                    rdata_nxt = rx_nxt[7:0];
                end else begin
                    st_nxt = SISP_LO;
                end
            end
            // reset pulsed high at least two cycles with clock low
            SISP_OFF: if (tmr_r == 32'h0 && SESSION) begin
                rst_nxt = 1'b0;
                st_nxt = SISP_IDLE;
            end
            default: st_nxt = SISP_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= SISP_PWR;
            sh_r <= 32'h0;
            bit_r <= 6'h00;
            tmr_r <= 32'(POWERUP_CYC);
            rx_r <= 32'h0;
            sck_r <= 1'b0;
            rst_r <= 1'b0;
            DONE <= 1'b0;
            ECHO <= 8'h00;
            RDATA <= 8'h00;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            tmr_r <= tmr_nxt;
            rx_r <= rx_nxt;
            sck_r <= sck_nxt;
            rst_r <= rst_nxt;
            DONE <= done_nxt;
            ECHO <= echo_nxt;
            RDATA <= rdata_nxt;
        end
    end
endmodule : sisp_prog
`default_nettype wire

// file: sisp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sisp_checker #(
    parameter int POWERUP_CYC = 10
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic rst_pin_n,
    input wire logic PROG_MODE,
    input wire logic BUSY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////
    // saturates so a long run cannot wrap back into the power-up window
    logic [15:0] pu_cnt_r;
    logic [15:0] pu_cnt_nxt;
    always_comb begin
        pu_cnt_nxt = (pu_cnt_r == 16'hFFFF) ? pu_cnt_r : pu_cnt_r + 16'h0001;
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pu_cnt_r <= 16'h0000;
        end else begin
            pu_cnt_r <= pu_cnt_nxt;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_high_hold;
        sck [*2];
    endsequence
    sequence s_low_hold;
        !sck [*2];
    endsequence
    property p_sck_high;
        $rose(sck) |=> s_high_hold;
    endproperty
    a_sck_high: assert property (p_sck_high) else $error("sck high too short");
    property p_sck_low;
        $fell(sck) |=> s_low_hold;
    endproperty
    a_sck_low: assert property (p_sck_low) else $error("sck low too short");
    property p_mosi_stable;
        sck && $past(sck) |-> $stable(mosi);
    endproperty
    a_mosi_stable: assert property (p_mosi_stable) else $error("mosi moved while sck high");
    property p_miso_fall;
        miso_oe && $past(miso_oe) && $changed(miso) |-> !sck;
    endproperty
    a_miso_fall: assert property (p_miso_fall) else $error("miso moved while sck high");
    property p_sck_idle;
        rst_pin_n |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck active outside session");
    property p_powerup;
        (int'(pu_cnt_r) < POWERUP_CYC) |-> !sck;
    endproperty
    a_powerup: assert property (p_powerup) else $error("sck before power-up wait");
    property p_oe_on;
        !rst_pin_n [*5] |-> miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven in session");
    property p_leave;
        rst_pin_n [*5] |-> !miso_oe && !PROG_MODE;
    endproperty
    a_leave: assert property (p_leave) else $error("still in programming mode");
    property p_busy_mode;
        $rose(BUSY) |-> $past(PROG_MODE);
    endproperty
    a_busy_mode: assert property (p_busy_mode) else $error("write ran before enable");
    property p_busy_hold;
        $rose(BUSY) |=> BUSY [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("pending dropped early");
endmodule : sisp_checker
`default_nettype wire

// file: sisp_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sisp_bench;
    localparam int PU_CYC = 10;
    logic clk, reset_n, start, session, ready, done, prog_mode, busy;
    logic [31:0] cmd;
    logic [7:0] echo, rdata;
    int miscompares, n_compared;
    sisp_if link();
    sisp_device i_sisp_device (.CLK(clk), .RESET_N(reset_n), .LINK(link), .PROG_MODE(prog_mode), .BUSY(busy));
    sisp_prog #(.POWERUP_CYC(PU_CYC)) i_sisp_prog (.CLK(clk), .RESET_N(reset_n), .LINK(link), .START(start),
        .CMD(cmd), .SESSION(session), .READY(ready), .DONE(done), .ECHO(echo), .RDATA(rdata));
    sisp_checker #(.POWERUP_CYC(PU_CYC)) i_sisp_checker (.CLK(clk), .RESET_N(reset_n), .sck(link.sck),
        .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .rst_pin_n(link.rst_pin_n),
        .PROG_MODE(prog_mode), .BUSY(busy));
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // one whole four-byte frame; bounded waits so a stuck link shows as a mismatch
    task automatic xfer(input logic [31:0] c);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        start = 1'b1;
        cmd = c;
        @(negedge clk);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("done", {7'h00, done}, 8'h01);
    endtask : xfer
    task automatic rd(input logic [31:0] c, input logic [7:0] exp);
        xfer(c);
        check("rdata", rdata, exp);
    endtask : rd
    // polling instead of fixed waits keeps the run short
    task automatic poll(input logic exp_first);
        int n;
        xfer(32'hF000_0000);
        check("pending", {7'h00, rdata[0]}, {7'h00, exp_first});
        n = 0;
        while (rdata[0] !== 1'b0 && n < 300) begin
            xfer(32'hF000_0000);
            n++;
        end
        check("pending", {7'h00, rdata[0]}, 8'h00);
    endtask : poll
    task automatic prog_enable();
        xfer(32'hAC53_0000);
        check("echo", echo, sisp_pkg::SUB_ENABLE);
        check("mode", {7'h00, prog_mode}, 8'h01);
    endtask : prog_enable
    // core reset between frames: memories keep their contents, pending work is dropped
    task automatic core_reset();
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        check("busy", {7'h00, busy}, 8'h00);
        check("mode", {7'h00, prog_mode}, 8'h00);
    endtask : core_reset
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        // one eeprom write wait plus about fifty frames, with margin
        repeat (80000) @(posedge clk);
        $display("BAD watchdog expected end seen hang");
        miscompares++;
        test_done();
    end
    initial begin
        miscompares = 0;
        n_compared = 0;
        reset_n = 1'b0;
        start = 1'b0;
        cmd = 32'h0000_0000;
        session = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        session = 1'b1;
        xfer(32'hC002_A55A);
        check("mode", {7'h00, prog_mode}, 8'h00);
        check("busy", {7'h00, busy}, 8'h00);
        $display("test refuse done");
        prog_enable();
        $display("test enable done");
        rd(32'h3000_0000, sisp_pkg::SIG_BYTE0);
        rd(32'h3000_0100, sisp_pkg::SIG_BYTE1);
        rd(32'h3000_0200, sisp_pkg::SIG_BYTE2);
        rd(32'h3800_0000, sisp_pkg::CAL_BYTE);
        rd(32'h5000_0000, sisp_pkg::FUSE_RESET);
        rd(32'h5808_0000, sisp_pkg::FUSE_RESET);
        rd(32'h5008_0000, sisp_pkg::FUSE_RESET);
        rd(32'h5800_0000, 8'hFF);
        $display("test id reads done");
        xfer(32'hACA0_00E2);
        rd(32'h5000_0000, 8'hE2);
        xfer(32'hACA8_00D9);
        rd(32'h5808_0000, 8'hD9);
        xfer(32'hACA4_00FD);
        rd(32'h5008_0000, 8'hFD);
        $display("test fuse done");
        xfer(32'hC002_A53C);
        poll(1'b1);
        rd(32'hA002_A500, 8'h3C);
        $display("test eeprom done");
        // low 6 bits index the buffer; page comes only from the commit
        xfer(32'h4000_07D2);
        xfer(32'h4800_07E7);
        xfer(32'h4000_0811);
        xfer(32'h4800_0822);
        xfer(32'h4D00_0000);
        xfer(32'h4C01_4000);
        check("busy", {7'h00, busy}, 8'h01);
        // the page write's busy wait is cut short by a core reset instead of probing the link
        core_reset();
        prog_enable();
        rd(32'h2001_4700, 8'hD2);
        rd(32'h2801_4700, 8'hE7);
        rd(32'h2001_4800, 8'h11);
        rd(32'h2801_4800, 8'h22);
        $display("test page done");
        xfer(32'hC100_0077);
        xfer(32'hC202_A400);
        rd(32'hA002_A400, 8'h77);
        rd(32'hA002_A500, 8'h3C);
        check("busy", {7'h00, busy}, 8'h01);
        xfer(32'hAC80_0000);
        rd(32'h2001_4700, 8'hD2);
        $display("test eeprom page done");
        core_reset();
        prog_enable();
        xfer(32'hACE0_00FC);
        rd(32'h5800_0000, 8'hFC);
        xfer(32'hAC80_0000);
        rd(32'h2001_4700, 8'hFF);
        rd(32'hA002_A400, 8'hFF);
        rd(32'h5800_0000, 8'hFF);
        rd(32'hF000_0000, 8'h01);
        $display("test erase done");
        session = 1'b0;
        repeat (20) @(negedge clk);
        check("mode", {7'h00, prog_mode}, 8'h00);
        session = 1'b1;
        prog_enable();
        $display("test leave done");
        test_done();
    end
endmodule : sisp_bench
`default_nettype wire
